// File: logic/pmsa_pkg.sv
// Constants and types for the management status and advertisement register bank
// Behaviour
// - 100BASE-TX full and half duplex ability read 1, 0 under ten-meg-only strap.
// - 10BASE-T full and half duplex ability bits always read 1.
// - Status bits 15 and 10:7 read zero; writes do nothing.
// - Preamble suppression bit reads 0; every frame needs the full preamble.
// - Negotiation-complete bit follows the negotiation done input, resets to 0.
// - Remote fault status bit follows the detected fault, resets to 0.
// - Auto-negotiation ability bit always reads 1.
// - Link status bit reads link validity, latches low, resets to 0.
// - Jabber bit latches high on jabber, used in 10BASE-T, resets to 0.
// - Extended capability bit always reads 1.
// - Fixed identifier split over registers 2 (upper) and 3 (lower), both constant.
// - Advertisement next-page bit and bit 14 read constant 0.
// - Advertisement remote fault bit is writable, resets to 0.
// - Technology ability field bits 12:5 writable, resets to 00101111.
// - Selector field bits 4:0 read only, fixed at 00001.
// - Partner page captured read only: next page, fault, ability, selector.
// - Partner acknowledge bit set once the partner page is received.
// - Latch-low and latch-high bits hold their state after the event.
package pmsa_pkg;
    // Management frame framing
    localparam logic [5:0] PRE_LEN = 6'h20;
    localparam logic [3:0] HDR_LAST = 4'hB;
    localparam logic [3:0] DATA_LAST = 4'hF;
    localparam logic [1:0] OP_RD = 2'h2;
    localparam logic [1:0] OP_WR = 2'h1;
    // Register addresses
    localparam logic [4:0] REG_STATUS = 5'h01;
    localparam logic [4:0] REG_ID_UP = 5'h02;
    localparam logic [4:0] REG_ID_LO = 5'h03;
    localparam logic [4:0] REG_ADV = 5'h04;
    localparam logic [4:0] REG_LP = 5'h05;
    // Identifier values, arbitrary
    localparam logic [15:0] ID_UPPER = 16'h1234;
    localparam logic [15:0] ID_LOWER = 16'h5678;
    // Advertisement layout
    localparam logic [15:0] ADV_RST = 16'h05E1;
    localparam logic [15:0] ADV_WMASK = 16'h3FE0;
    localparam logic [4:0] ADV_SEL = 5'h01;
    localparam int LP_ACK = 14;
    // Status bit positions
    localparam int ST_TX_FD = 14;
    localparam int ST_TX_HD = 13;
    localparam int ST_T_FD = 12;
    localparam int ST_T_HD = 11;
    localparam int ST_PRE_SUP = 6;
    localparam int ST_AN_DONE = 5;
    localparam int ST_RFAULT = 4;
    localparam int ST_AN_ABLE = 3;
    localparam int ST_LINK = 2;
    localparam int ST_JAB = 1;
    localparam int ST_EXT = 0;
    localparam logic [15:0] ST_RSVD_MASK = 16'h8780;

    typedef enum logic [2:0] {
        PMSA_PRE = 3'h0,
        PMSA_ST = 3'h1,
        PMSA_HDR = 3'h3,
        PMSA_TA = 3'h2,
        PMSA_DAT = 3'h6
    } pmsa_state_t;

    typedef struct packed {
        pmsa_state_t state;
        logic [5:0] pre_cnt;
        logic [3:0] cnt;
        logic [11:0] hdr;
        logic [15:0] sh;
        logic mdc_q;
        logic mdio_out;
        logic mdio_oe;
        logic strap_done;
        logic strap_q;
        logic an_done;
        logic rfault;
        logic link_lat;
        logic jab_lat;
        logic [15:0] adv;
        logic [15:0] lp;
    } pmsa_st_t;

    localparam pmsa_st_t ST_RST = '{
        state: PMSA_PRE, pre_cnt: 6'h00, cnt: 4'h0, hdr: 12'h000,
        sh: 16'h0000, mdc_q: 1'b0, mdio_out: 1'b0, mdio_oe: 1'b0,
        strap_done: 1'b0, strap_q: 1'b0, an_done: 1'b0, rfault: 1'b0,
        link_lat: 1'b0, jab_lat: 1'b0, adv: ADV_RST, lp: 16'h0000};
endpackage

// File: logic/pmsa_regs.sv
// Management frame slave with status, identifier and advertisement registers
`timescale 1ns/100ps
`default_nettype none
module pmsa_regs
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic [4:0] phy_addr,
    input wire logic ten_meg_only_advert_strap,
    input wire logic an_complete,
    input wire logic remote_fault_det,
    input wire logic link_valid,
    input wire logic jabber_det,
    input wire logic lp_page_valid,
    input wire logic [15:0] lp_page,
    output logic [15:0] adv_page
);
    import pmsa_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [15:0] rd_mux(
        input logic [4:0] a,
        input logic [15:0] stat,
        input logic [15:0] adv,
        input logic [15:0] lp
    );
        logic [15:0] r;
        r = 16'h0000;
        case (a)
            REG_STATUS: r = stat;
            REG_ID_UP: r = ID_UPPER;
            REG_ID_LO: r = ID_LOWER;
            REG_ADV: r = adv;
            REG_LP: r = lp;
            default: r = 16'h0000;
        endcase
        return r;
    endfunction

    function automatic logic [15:0] adv_fix(input logic [15:0] d);
        return (d & ADV_WMASK) | {11'h000, ADV_SEL};
    endfunction

    // ==========================================================
    // State
    pmsa_st_t st;
    pmsa_st_t nx;
    logic rise;
    logic [11:0] hdr_n;
    logic [15:0] stat_w;
    logic [15:0] rd_w;
    logic [15:0] wr_w;
    logic rd_load;
    logic rd_stat;

    assign mdio_out = st.mdio_out;
    assign mdio_oe = st.mdio_oe;
    assign adv_page = st.adv;

    // ==========================================================
    // Status word
    always_comb
    begin
        stat_w = 16'h0000;
        stat_w[ST_TX_FD] = ~st.strap_q;
        stat_w[ST_TX_HD] = ~st.strap_q;
        stat_w[ST_T_FD] = 1'b1;
        stat_w[ST_T_HD] = 1'b1;
        stat_w[ST_AN_DONE] = st.an_done;
        stat_w[ST_RFAULT] = st.rfault;
        stat_w[ST_AN_ABLE] = 1'b1;
        stat_w[ST_LINK] = st.link_lat;
        stat_w[ST_JAB] = st.jab_lat;
        stat_w[ST_EXT] = 1'b1;
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        nx = st;
        rise = mdc & ~st.mdc_q;
        hdr_n = {st.hdr[10:0], mdio_in};
        wr_w = {st.sh[14:0], mdio_in};
        rd_w = rd_mux(st.hdr[4:0], stat_w, st.adv, st.lp);
        rd_load = 1'b0;
        nx.mdc_q = mdc;
        if (!st.strap_done)
        begin
            nx.strap_done = 1'b1;
            nx.strap_q = ten_meg_only_advert_strap;
        end
        nx.an_done = an_complete;
        nx.rfault = remote_fault_det;
        nx.link_lat = st.link_lat & link_valid;
        nx.jab_lat = st.jab_lat | jabber_det;
        if (lp_page_valid)
        begin
            nx.lp = lp_page;
            nx.lp[LP_ACK] = 1'b1;
        end
        if (rise)
        begin
            case (st.state)
                PMSA_PRE:
                begin
                    if (mdio_in)
                    begin
                        if (st.pre_cnt != PRE_LEN)
                        begin
                            nx.pre_cnt = st.pre_cnt + 6'h01;
                        end
                    end
                    else if (st.pre_cnt == PRE_LEN)
                    begin
                        nx.state = PMSA_ST;
                    end
                    else
                    begin
                        nx.pre_cnt = 6'h00;
                    end
                end
                PMSA_ST:
                begin
                    nx.pre_cnt = 6'h00;
                    nx.cnt = 4'h0;
                    nx.state = mdio_in ? PMSA_HDR : PMSA_PRE;
                end
                PMSA_HDR:
                begin
                    nx.hdr = hdr_n;
                    nx.cnt = st.cnt + 4'h1;
                    if (st.cnt == HDR_LAST)
                    begin
                        nx.cnt = 4'h0;
                        if (hdr_n[9:5] == phy_addr &&
                            (hdr_n[11:10] == OP_RD || hdr_n[11:10] == OP_WR))
                        begin
                            nx.state = PMSA_TA;
                        end
                        else
                        begin
                            nx.state = PMSA_PRE;
                        end
                    end
                end
                PMSA_TA:
                begin
                    nx.cnt = 4'h0;
                    if (st.cnt == 4'h0)
                    begin
                        nx.cnt = 4'h1;
                        if (st.hdr[11:10] == OP_RD)
                        begin
                            nx.mdio_oe = 1'b1;
                            nx.mdio_out = 1'b0;
                        end
                    end
                    else
                    begin
                        nx.state = PMSA_DAT;
                        if (st.hdr[11:10] == OP_RD)
                        begin
                            rd_load = 1'b1;
                            nx.sh = rd_w;
                            nx.mdio_out = rd_w[15];
                        end
                    end
                end
                PMSA_DAT:
                begin
                    nx.cnt = st.cnt + 4'h1;
                    nx.sh = wr_w;
                    if (st.hdr[11:10] == OP_RD)
                    begin
                        nx.mdio_out = st.sh[14];
                    end
                    if (st.cnt == DATA_LAST)
                    begin
                        nx.cnt = 4'h0;
                        nx.state = PMSA_PRE;
                        nx.mdio_oe = 1'b0;
                        nx.mdio_out = 1'b0;
                        if (st.hdr[11:10] == OP_WR && st.hdr[4:0] == REG_ADV)
                        begin
                            nx.adv = adv_fix(wr_w);
                        end
                    end
                end
                default:
                begin
                    nx = ST_RST;
                end
            endcase
        end
        rd_stat = rd_load && st.hdr[4:0] == REG_STATUS;
        if (rd_stat)
        begin
            // Snapshot already taken above, so a same-cycle event still shows
            nx.link_lat = link_valid;
            nx.jab_lat = jabber_det;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= ST_RST;
        end
        else
        begin
            st <= nx;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_rd_ta;
        rise && st.state == PMSA_TA && st.cnt == 4'h0 && st.hdr[11:10] == OP_RD;
    endsequence

    sequence s_stat_rd;
        rise && st.state == PMSA_TA && st.cnt == 4'h1 && st.hdr[11:10] == OP_RD
            && st.hdr[4:0] == REG_STATUS;
    endsequence

    sequence s_adv_wr;
        rise && st.state == PMSA_DAT && st.cnt == DATA_LAST && st.hdr[11:10] == OP_WR
            && st.hdr[4:0] == REG_ADV;
    endsequence

    sequence s_frame_end;
        rise && st.state == PMSA_DAT && st.cnt == DATA_LAST;
    endsequence

    sequence s_addr_miss;
        rise && st.state == PMSA_HDR && st.cnt == HDR_LAST && hdr_n[9:5] != phy_addr;
    endsequence

    AST_TX_ABIL: assert property (st.strap_done |->
        stat_w[ST_TX_FD] == stat_w[ST_TX_HD] && stat_w[ST_TX_FD] != st.strap_q)
        else $error("100BASE-TX ability does not follow strap");

    AST_FIXED_ONES: assert property (stat_w[ST_T_FD] && stat_w[ST_T_HD]
        && stat_w[ST_AN_ABLE] && stat_w[ST_EXT])
        else $error("fixed ability bits not set");

    AST_RSVD_ZERO: assert property ((stat_w & ST_RSVD_MASK) == 16'h0000)
        else $error("reserved status bits not zero");

    AST_NO_SHORT_PRE: assert property ($rose(st.state == PMSA_ST) |->
        $past(st.pre_cnt) == PRE_LEN && stat_w[ST_PRE_SUP] == 1'b0)
        else $error("frame started without full preamble");

    AST_AN_DONE: assert property (an_complete |=> stat_w[ST_AN_DONE])
        else $error("negotiation complete not reported");

    AST_LINK_LL: assert property (!link_valid && !rd_stat |=> !st.link_lat)
        else $error("link status failed to latch low");

    AST_JAB_LH: assert property (jabber_det |=> st.jab_lat ##1 st.jab_lat || $past(rd_stat))
        else $error("jabber failed to latch high");

    AST_ADV_FIXED: assert property (st.adv[15:14] == 2'h0 && st.adv[4:0] == ADV_SEL)
        else $error("advertisement fixed bits changed");

    AST_LP_CAPT: assert property (lp_page_valid |=> st.lp[LP_ACK]
        && st.lp[13:0] == $past(lp_page[13:0]) && st.lp[15] == $past(lp_page[15]))
        else $error("partner page not captured");

    AST_RELEASE: assert property (s_stat_rd |=> st.link_lat == $past(link_valid)
        && st.jab_lat == $past(jabber_det))
        else $error("latched bits not released after read");

    AST_STRAP: assert property ($rose(st.strap_done) |->
        st.strap_q == $past(ten_meg_only_advert_strap))
        else $error("strap not sampled after reset");

    AST_TA_DRIVE: assert property (s_rd_ta |=> mdio_oe && !mdio_out)
        else $error("read turnaround not driven low");

    AST_RFAULT_LIVE: assert property ($past(nrst) |->
        stat_w[ST_RFAULT] == $past(remote_fault_det))
        else $error("remote fault status does not follow its input");

    AST_AN_LIVE: assert property ($past(nrst) |->
        stat_w[ST_AN_DONE] == $past(an_complete))
        else $error("negotiation complete bit does not follow its input");

    AST_ADV_WRITE: assert property (s_adv_wr |=>
        st.adv[13:5] == $past(wr_w[13:5]))
        else $error("advertisement write not applied");

    AST_ADV_HOLD: assert property ($changed(st.adv) |->
        $past(rise && st.state == PMSA_DAT && st.cnt == DATA_LAST
        && st.hdr[11:10] == OP_WR && st.hdr[4:0] == REG_ADV))
        else $error("advertisement changed without a write");

    AST_LP_HOLD: assert property ($changed(st.lp) |-> $past(lp_page_valid))
        else $error("partner page changed without a new page");

    AST_ID_UP_READ: assert property (rd_load && st.hdr[4:0] == REG_ID_UP |=>
        st.sh == ID_UPPER)
        else $error("upper identifier read wrong");

    AST_ID_LO_READ: assert property (rd_load && st.hdr[4:0] == REG_ID_LO |=>
        st.sh == ID_LOWER)
        else $error("lower identifier read wrong");

    AST_STAT_READ: assert property (rd_stat |=>
        st.sh[ST_PRE_SUP] == 1'b0 && (st.sh & ST_RSVD_MASK) == 16'h0000)
        else $error("status read shows reserved or suppression bits set");

    AST_ADV_READ: assert property (rd_load && st.hdr[4:0] == REG_ADV |=>
        st.sh[15:14] == 2'h0 && st.sh[4:0] == ADV_SEL)
        else $error("advertisement fixed fields read wrong");

    AST_LP_READ: assert property (rd_load && st.hdr[4:0] == REG_LP |=>
        st.sh == $past(st.lp))
        else $error("partner page read wrong");

    AST_UNMAPPED: assert property (rd_load
        && (st.hdr[4:0] < REG_STATUS || st.hdr[4:0] > REG_LP) |=> st.sh == 16'h0000)
        else $error("unmapped register did not read zero");

    AST_DATA_FIRST: assert property (rd_load |=> mdio_oe && mdio_out == $past(rd_w[15]))
        else $error("first read data bit not driven");

    AST_OE_END: assert property (s_frame_end |=> !mdio_oe && st.state == PMSA_PRE)
        else $error("data line not released at frame end");

    AST_ADDR_MISS: assert property (s_addr_miss |=> st.state == PMSA_PRE && !mdio_oe)
        else $error("frame for another address not ignored");

    AST_HUNT_QUIET: assert property (st.state == PMSA_PRE || st.state == PMSA_ST
        || st.state == PMSA_HDR |-> !mdio_oe)
        else $error("data line driven outside a read");

    AST_WR_QUIET: assert property (st.state == PMSA_DAT && st.hdr[11:10] == OP_WR |-> !mdio_oe)
        else $error("data line driven during a write");
endmodule
`default_nettype wire

// File: test/pmsa_mac.sv
// Management frame master model driving the clock and data lines
`timescale 1ns/100ps
`default_nettype none
module pmsa_mac
(
    input wire logic sys_clk,
    input wire logic mdio,
    output logic mdc,
    output logic host_d,
    output logic host_en,
    output logic rd_valid,
    output logic [15:0] rd_data
);
    initial
    begin
        mdc = 1'b0;
        host_d = 1'b0;
        host_en = 1'b0;
        rd_valid = 1'b0;
        rd_data = 16'h0000;
    end

    // =========================================================
    // One frame; mdc stands low between frames
    task automatic xfer(input int pre, input logic [1:0] op, input logic [4:0] phy,
        input logic [4:0] ra, input logic [15:0] wd);
        logic [31:0] body;
        logic rd;
        body = {2'b01, op, phy, ra, 2'b10, wd};
        rd = (op == 2'h2);
        for (int j = pre + 31; j >= 0; j--)
        begin
            @(posedge sys_clk);
            mdc <= 1'b0;
            // Released from the first turnaround bit on a read
            host_en <= !(rd && j <= 17);
            host_d <= (j > 31) ? 1'b1 : body[j];
            repeat (2) @(posedge sys_clk);
            mdc <= 1'b1;
            repeat (3) @(posedge sys_clk);
            if (rd && j >= 1 && j <= 16)
                rd_data[j - 1] <= mdio;
        end
        @(posedge sys_clk);
        mdc <= 1'b0;
        host_en <= 1'b0;
        rd_valid <= rd;
        @(posedge sys_clk);
        rd_valid <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: test/pmsa_regs_tb_top.sv
// Self-checking bench for the management status and advertisement register bank
`timescale 1ns/100ps
`default_nettype none
module pmsa_regs_tb_top;
    import pmsa_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic mdc, host_d, host_en, rd_valid, dut_out, dut_oe, mdio;
    logic strap = 1'b0, an_done = 1'b0, rf = 1'b0, link = 1'b1, jab = 1'b0, lp_v = 1'b0;
    logic [4:0] phy = 5'h0B;
    logic [15:0] lp = 16'h0000, rd_data, adv, v;
    logic [15:0] expq[$];
    int err_total = 0, checked = 0, cyc = 0, seed = 12;

    always #5 sys_clk = ~sys_clk;
    // Pull-up holds the wire high when nobody drives it
    assign mdio = dut_oe ? dut_out : (host_en ? host_d : 1'b1);

    pmsa_mac mac (.sys_clk(sys_clk), .mdio(mdio), .mdc(mdc), .host_d(host_d),
        .host_en(host_en), .rd_valid(rd_valid), .rd_data(rd_data));
    pmsa_regs dut (.sys_clk(sys_clk), .nrst(nrst), .mdc(mdc), .mdio_in(mdio),
        .mdio_out(dut_out), .mdio_oe(dut_oe), .phy_addr(phy),
        .ten_meg_only_advert_strap(strap), .an_complete(an_done),
        .remote_fault_det(rf), .link_valid(link), .jabber_det(jab),
        .lp_page_valid(lp_v), .lp_page(lp), .adv_page(adv));

    // =========================================================
    // Checking and reporting
    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (rd_valid)
            chk(expq.pop_front(), rd_data);
        if (cyc == 20000)
        begin
            err_total++;
            results();
        end
    end

    // =========================================================
    // Stimulus tasks
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic rd(input logic [4:0] ra, input logic [15:0] exp, input int pre = 32,
        input logic [4:0] pa = 5'h0B);
        expq.push_back(exp);
        mac.xfer(pre, OP_RD, pa, ra, 16'h0000);
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        mac.xfer(32, OP_WR, phy, ra, d);
    endtask

    // =========================================================
    // Main sequence
    initial
    begin
        do_reset();
        rd(REG_STATUS, 16'h7809);
        rd(REG_STATUS, 16'h780D);
        @(posedge sys_clk);
        an_done <= 1'b1;
        rf <= 1'b1;
        jab <= 1'b1;
        link <= 1'b0;
        @(posedge sys_clk);
        jab <= 1'b0;
        link <= 1'b1;
        rd(REG_STATUS, 16'h783B);
        rd(REG_STATUS, 16'h783D);
        rd(REG_ID_UP, ID_UPPER);
        rd(REG_ID_LO, ID_LOWER);
        rd(REG_ADV, 16'h05E1);
        chk(16'h05E1, adv);
        for (int i = 0; i < 4; i++)
        begin
            v = (i == 0) ? 16'hFFFF : 16'($random(seed));
            wr(REG_ADV, v);
            rd(REG_ADV, (v & 16'h3FE0) | 16'h0001);
        end
        mac.xfer(32, 2'h3, phy, REG_ADV, 16'h0000);
        mac.xfer(32, OP_WR, phy ^ 5'h01, REG_ADV, 16'h0000);
        mac.xfer(31, OP_WR, phy, REG_ADV, 16'h0000);
        chk((v & 16'h3FE0) | 16'h0001, adv);
        wr(REG_STATUS, 16'hFFFF);
        rd(REG_STATUS, 16'h783D);
        v = 16'($random(seed));
        @(posedge sys_clk);
        lp <= v;
        lp_v <= 1'b1;
        @(posedge sys_clk);
        lp_v <= 1'b0;
        lp <= ~v;
        rd(REG_LP, v | 16'h4000);
        rd(5'h00, 16'h0000);
        rd(5'h06, 16'h0000);
        rd(REG_STATUS, 16'hFFFF, 31);
        rd(REG_STATUS, 16'hFFFF, 32, phy ^ 5'h01);
        strap <= 1'b1;
        do_reset();
        strap <= 1'b0;
        rd(REG_STATUS, 16'h1839);
        repeat (8) @(posedge sys_clk);
        results();
    end
endmodule
`default_nettype wire
